// ### core/tlvi_arbiter.v
// fixed-order two-level arbiter returning the winning source index
`include "tlvi_map.vh"
`default_nettype none
module tlvi_arbiter #(
   parameter NSRC = `TLVI_NSRC
) (
   input  wire [NSRC-1:0] req_i,
   input  wire [NSRC-1:0] prio_i,
   output reg             hit_o,
   output reg             hit_high_o,
   output reg  [3:0]      win_o
);
   // ============================================================
   // search
   integer k;
   reg [NSRC-1:0] hi_req;
   always @* begin
      hit_o      = 1'b0;
      hit_high_o = 1'b0;
      win_o      = 4'h0;
      hi_req     = req_i & prio_i;
      // descending loop so the lowest index (earliest poll) ends up winning
      for (k = NSRC-1; k >= 0; k = k - 1) begin
         if (req_i[k] && !hi_req[k] && (hi_req == {NSRC{1'b0}})) begin
            hit_o = 1'b1;
            win_o = k[3:0];
         end
      end
      for (k = NSRC-1; k >= 0; k = k - 1) begin
         if (hi_req[k]) begin
            hit_o      = 1'b1;
            hit_high_o = 1'b1;
            win_o      = k[3:0];
         end
      end
   end
endmodule
`default_nettype wire

// ### core/tlvi_ctrl.v
// two-level vectored interrupt controller top
//
// Summary of operation
// - eleven sources, high and low levels
// - per-source priority bit selects level
// - defer while equal/higher level active
// - high request preempts low routine
// - fixed polling order breaks ties
// - per-source enables plus global enable
// - sample each cycle, poll next cycle
// - winning request forces long call
// - four conditions block the call
// - blocked requests are not remembered
// - push pc only, load vector
// - fixed vector address per source
// - return-from-interrupt clears level
// - plain return leaves level active
// - entry clears edge, timer0/1, spi, i2c flags
// - external inputs edge or level triggered
`include "tlvi_map.vh"
`default_nettype none
module tlvi_ctrl #(
   parameter NSRC = `TLVI_NSRC
) (
   input  wire            ref_clk_i,
   input  wire            reset_i,
   input  wire            machine_cycle_i,
   input  wire            last_cycle_i,
   input  wire            enable_write_i,
   input  wire            reti_i,
   input  wire            global_int_enable_i,
   input  wire [NSRC-1:0] src_enable_i,
   input  wire [NSRC-1:0] src_priority_i,
   input  wire            ext0_trigger_type_i,
   input  wire            ext1_trigger_type_i,
   input  wire            ext0_pin_n_i,
   input  wire            ext1_pin_n_i,
   input  wire            timer0_overflow_i,
   input  wire            timer1_overflow_i,
   input  wire            spi_event_i,
   input  wire            i2c_event_i,
   input  wire [NSRC-1:0] level_flag_i,
   input  wire [15:0]     pc_i,
   output reg             call_req_o,
   output reg             push_valid_o,
   output reg  [7:0]      push_byte_o,
   output reg             pc_load_o,
   output reg  [15:0]     pc_vector_o,
   output reg  [NSRC-1:0] pending_o,
   output reg  [NSRC-1:0] flag_clear_o,
   output reg             active_high_o,
   output reg             active_low_o
);
   // ============================================================
   // vector lookup
   function [15:0] vec_of;
      input [3:0] idx;
      begin
         case (idx)
            4'h0:    vec_of = `TLVI_VEC_EXT0;
            4'h1:    vec_of = `TLVI_VEC_TMR0;
            4'h2:    vec_of = `TLVI_VEC_EXT1;
            4'h3:    vec_of = `TLVI_VEC_TMR1;
            4'h4:    vec_of = `TLVI_VEC_UART0;
            4'h5:    vec_of = `TLVI_VEC_TMR2;
            4'h6:    vec_of = `TLVI_VEC_SPI;
            4'h7:    vec_of = `TLVI_VEC_I2C;
            4'h8:    vec_of = `TLVI_VEC_ADC;
            4'h9:    vec_of = `TLVI_VEC_PCA;
            4'ha:    vec_of = `TLVI_VEC_UART1;
            default: vec_of = 16'h0000;
         endcase
      end
   endfunction

   // ============================================================
   // hardware-set flags: external pins, timer0/1, spi, i2c
   reg        ext0_pin_d;
   reg        ext1_pin_d;
   reg        ext0_pending_flag;
   reg        ext1_pending_flag;
   reg        timer0_overflow_flag;
   reg        timer1_overflow_flag;
   reg        spi_flag;
   reg        i2c_flag;
   wire       ext0_set;
   wire       ext1_set;
   wire       ext0_lvl;
   wire       ext1_lvl;
   // trigger type 1 = falling edge, 0 = low level
   function fall_seen;
      input trig_edge;
      input pin_prev;
      input pin_now_n;
      begin
         fall_seen = trig_edge & pin_prev & ~pin_now_n;
      end
   endfunction
   assign ext0_set = fall_seen(ext0_trigger_type_i, ext0_pin_d, ext0_pin_n_i);
   assign ext1_set = fall_seen(ext1_trigger_type_i, ext1_pin_d, ext1_pin_n_i);
   assign ext0_lvl = ~ext0_trigger_type_i & ~ext0_pin_n_i;
   assign ext1_lvl = ~ext1_trigger_type_i & ~ext1_pin_n_i;

   wire [NSRC-1:0] hw_clear;
   reg  [NSRC-1:0] raw_flags;
   always @* begin
      raw_flags = level_flag_i;
      raw_flags[`TLVI_SRC_EXT0] = ext0_pending_flag | ext0_lvl;
      raw_flags[`TLVI_SRC_TMR0] = timer0_overflow_flag;
      raw_flags[`TLVI_SRC_EXT1] = ext1_pending_flag | ext1_lvl;
      raw_flags[`TLVI_SRC_TMR1] = timer1_overflow_flag;
      raw_flags[`TLVI_SRC_SPI]  = spi_flag;
      raw_flags[`TLVI_SRC_I2C]  = i2c_flag;
   end

   // set wins over the entry clear so a coincident event is kept
   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ext0_pin_d           <= 1'b1;
         ext1_pin_d           <= 1'b1;
         ext0_pending_flag    <= 1'b0;
         ext1_pending_flag    <= 1'b0;
         timer0_overflow_flag <= 1'b0;
         timer1_overflow_flag <= 1'b0;
         spi_flag             <= 1'b0;
         i2c_flag             <= 1'b0;
      end else begin
         ext0_pin_d <= ext0_pin_n_i;
         ext1_pin_d <= ext1_pin_n_i;
         if (ext0_set)
            ext0_pending_flag <= 1'b1;
         else if (hw_clear[`TLVI_SRC_EXT0])
            ext0_pending_flag <= 1'b0;
         if (ext1_set)
            ext1_pending_flag <= 1'b1;
         else if (hw_clear[`TLVI_SRC_EXT1])
            ext1_pending_flag <= 1'b0;
         if (timer0_overflow_i)
            timer0_overflow_flag <= 1'b1;
         else if (hw_clear[`TLVI_SRC_TMR0])
            timer0_overflow_flag <= 1'b0;
         if (timer1_overflow_i)
            timer1_overflow_flag <= 1'b1;
         else if (hw_clear[`TLVI_SRC_TMR1])
            timer1_overflow_flag <= 1'b0;
         if (spi_event_i)
            spi_flag <= 1'b1;
         else if (hw_clear[`TLVI_SRC_SPI])
            spi_flag <= 1'b0;
         if (i2c_event_i)
            i2c_flag <= 1'b1;
         else if (hw_clear[`TLVI_SRC_I2C])
            i2c_flag <= 1'b0;
      end
   end

   // ============================================================
   // sample and poll
   reg  [NSRC-1:0] sampled;
   wire [NSRC-1:0] gated;
   wire            hit;
   wire            hit_high;
   wire [3:0]      win;
   // enables apply at poll time; sampled word is rebuilt every machine cycle
   assign gated = global_int_enable_i ? (sampled & src_enable_i) : {NSRC{1'b0}};

   tlvi_arbiter #(
      .NSRC (NSRC)
   ) u_arb (
      .req_i      (gated),
      .prio_i     (src_priority_i),
      .hit_o      (hit),
      .hit_high_o (hit_high),
      .win_o      (win)
   );

   reg  [1:0]  state;
   reg  [1:0]  next_state;
   reg  [15:0] saved_pc;
   reg  [15:0] saved_vec;
   reg         active_high;
   reg         active_low;
   wire        level_ok;
   wire        take;
   // equal-or-higher active blocks; high request passes a low routine
   assign level_ok = hit_high ? ~active_high : (~active_high & ~active_low);
   assign take = (state == `TLVI_ST_IDLE) & machine_cycle_i & hit & level_ok & last_cycle_i
                 & ~enable_write_i & ~reti_i;

   reg [NSRC-1:0] clr_onehot;
   always @* begin
      clr_onehot = {NSRC{1'b0}};
      if (take)
         clr_onehot[win] = 1'b1;
   end
   // level-mode external inputs keep their flag
   function [NSRC-1:0] clear_mask;
      input ext0_edge;
      input ext1_edge;
      begin
         clear_mask = `TLVI_AUTOCLR_MASK;
         clear_mask[`TLVI_SRC_EXT0] = ext0_edge;
         clear_mask[`TLVI_SRC_EXT1] = ext1_edge;
      end
   endfunction
   assign hw_clear = clr_onehot & clear_mask(ext0_trigger_type_i, ext1_trigger_type_i);

   always @* begin
      next_state = state;
      case (state)
         `TLVI_ST_IDLE: begin
            if (take)
               next_state = `TLVI_ST_PUSH_LO;
         end
         `TLVI_ST_PUSH_LO: next_state = `TLVI_ST_PUSH_HI;
         `TLVI_ST_PUSH_HI: next_state = `TLVI_ST_LOAD;
         `TLVI_ST_LOAD:    next_state = `TLVI_ST_IDLE;
         default:          next_state = `TLVI_ST_IDLE;
      endcase
   end

   // ============================================================
   // in-progress levels
   reg         next_active_high;
   reg         next_active_low;
   wire        reti_seen;
   // plain returns never reach here, so the level stays busy
   assign reti_seen = reti_i & machine_cycle_i & (state == `TLVI_ST_IDLE);
   always @* begin
      next_active_high = active_high;
      next_active_low  = active_low;
      if (take) begin
         if (hit_high)
            next_active_high = 1'b1;
         else
            next_active_low = 1'b1;
      end else if (reti_seen) begin
         // the highest busy level is the one being left
         if (active_high)
            next_active_high = 1'b0;
         else
            next_active_low = 1'b0;
      end
   end

   // ============================================================
   // sequencing and outputs
   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state         <= `TLVI_ST_IDLE;
         sampled       <= {NSRC{1'b0}};
         saved_pc      <= 16'h0000;
         saved_vec     <= 16'h0000;
         active_high   <= 1'b0;
         active_low    <= 1'b0;
         call_req_o    <= 1'b0;
         push_valid_o  <= 1'b0;
         push_byte_o   <= 8'h00;
         pc_load_o     <= 1'b0;
         pc_vector_o   <= 16'h0000;
         pending_o     <= {NSRC{1'b0}};
         flag_clear_o  <= {NSRC{1'b0}};
         active_high_o <= 1'b0;
         active_low_o  <= 1'b0;
      end else begin
         state <= next_state;
         // a fresh snapshot each machine cycle: nothing denied is kept
         if (machine_cycle_i)
            sampled <= raw_flags;
         pending_o    <= raw_flags;
         flag_clear_o <= hw_clear;
         call_req_o   <= take;
         push_valid_o <= 1'b0;
         pc_load_o    <= 1'b0;
         if (take) begin
            saved_pc  <= pc_i;
            saved_vec <= vec_of(win);
         end
         // outputs follow the level flags in the same cycle
         active_high   <= next_active_high;
         active_low    <= next_active_low;
         active_high_o <= next_active_high;
         active_low_o  <= next_active_low;
         // status word is not pushed, only the two pc bytes
         case (state)
            `TLVI_ST_PUSH_LO: begin
               push_valid_o <= 1'b1;
               push_byte_o  <= saved_pc[7:0];
            end
            `TLVI_ST_PUSH_HI: begin
               push_valid_o <= 1'b1;
               push_byte_o  <= saved_pc[15:8];
            end
            `TLVI_ST_LOAD: begin
               pc_load_o   <= 1'b1;
               pc_vector_o <= saved_vec;
            end
            default: begin
               push_byte_o <= push_byte_o;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ### core/tlvi_map.vh
// constants for the two-level vectored interrupt controller
`ifndef TLVI_MAP_VH
`define TLVI_MAP_VH
// ============================================================
// source index (polling order, 0 wins)
`define TLVI_NSRC        11
`define TLVI_SRC_EXT0    0
`define TLVI_SRC_TMR0    1
`define TLVI_SRC_EXT1    2
`define TLVI_SRC_TMR1    3
`define TLVI_SRC_UART0   4
`define TLVI_SRC_TMR2    5
`define TLVI_SRC_SPI     6
`define TLVI_SRC_I2C     7
`define TLVI_SRC_ADC     8
`define TLVI_SRC_PCA     9
`define TLVI_SRC_UART1   10
// ============================================================
// vector addresses
`define TLVI_VEC_EXT0    16'h0003
`define TLVI_VEC_TMR0    16'h000b
`define TLVI_VEC_EXT1    16'h0013
`define TLVI_VEC_TMR1    16'h001b
`define TLVI_VEC_UART0   16'h0023
`define TLVI_VEC_TMR2    16'h002b
`define TLVI_VEC_SPI     16'h0053
`define TLVI_VEC_I2C     16'h0043
`define TLVI_VEC_ADC     16'h003b
`define TLVI_VEC_PCA     16'h005b
`define TLVI_VEC_UART1   16'h004b
// ============================================================
// sources whose flag is cleared on entry (ext0/ext1 only when edge mode)
`define TLVI_AUTOCLR_MASK 11'h0ca
// ============================================================
// controller states
`define TLVI_ST_IDLE     2'h0
`define TLVI_ST_PUSH_LO  2'h1
`define TLVI_ST_PUSH_HI  2'h2
`define TLVI_ST_LOAD     2'h3
`endif

// ### test/tb_top.sv
// self-checking bench for the interrupt controller
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic        ref_clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        stall = 1'b0;
   logic        wr = 1'b0;
   logic        reti = 1'b0;
   logic        gie = 1'b1;
   logic        tt0 = 1'b1;
   logic        tt1 = 1'b1;
   logic        p0_n = 1'b1;
   logic        p1_n = 1'b1;
   logic [10:0] en = 11'h7ff;
   logic [10:0] pri = 11'h000;
   logic [10:0] ev = 11'h000;
   logic [10:0] lvl = 11'h000;
   logic [15:0] pc = 16'h0000;
   wire  logic  mc, lc, call, pv, pl, ahi, alo;
   wire  logic [7:0]  pb;
   wire  logic [15:0] vec, stk;
   wire  logic [10:0] clr, pend;
   int          error_cnt = 0;
   int          check_count = 0;
   logic [15:0] vt [0:10] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
                              16'h0053, 16'h0043, 16'h003b, 16'h005b, 16'h004b};
   tlvi_ctrl tlvi_ctrl_inst (.ref_clk_i, .reset_i, .machine_cycle_i(mc), .last_cycle_i(lc),
      .enable_write_i(wr), .reti_i(reti), .global_int_enable_i(gie), .src_enable_i(en),
      .src_priority_i(pri), .ext0_trigger_type_i(tt0), .ext1_trigger_type_i(tt1),
      .ext0_pin_n_i(p0_n), .ext1_pin_n_i(p1_n), .timer0_overflow_i(ev[1]),
      .timer1_overflow_i(ev[3]), .spi_event_i(ev[6]), .i2c_event_i(ev[7]),
      .level_flag_i(lvl), .pc_i(pc), .call_req_o(call), .push_valid_o(pv), .push_byte_o(pb),
      .pc_load_o(pl), .pc_vector_o(vec), .pending_o(pend), .flag_clear_o(clr),
      .active_high_o(ahi), .active_low_o(alo));
   tlvi_core_model tlvi_core_model_inst (.ref_clk_i, .reset_i, .stall_i(stall),
      .push_valid_i(pv), .push_byte_i(pb), .machine_cycle_o(mc), .last_cycle_o(lc),
      .stack_pc_o(stk));
   // ==========
   // helpers
   task automatic step();
      @(posedge ref_clk_i);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic raise(input int i);
      case (i)
         0: p0_n = 1'b0;
         2: p1_n = 1'b0;
         1, 3, 6, 7: begin ev[i] = 1'b1; step(); ev = 11'h000; end
         default: lvl[i] = 1'b1;
      endcase
   endtask
   task automatic drop(input int i);
      p0_n = 1'b1;
      p1_n = 1'b1;
      lvl[i] = 1'b0;
   endtask
   task automatic want(input int i, input logic hi);
      int n;
      logic ed;
      n = 0;
      ed = (i == 0) ? tt0 : (i == 2) ? tt1 : (i == 1 || i == 3 || i == 6 || i == 7);
      while (call !== 1'b1 && n < 40) begin step(); n++; end
      chk("call", 16'h1, {15'h0, call});
      chk("clear", ed ? 16'h1 << i : 16'h0, {5'h0, clr});
      repeat (4) step();
      chk("vector", vt[i], vec);
      chk("stack", pc, stk);
      chk("level", 16'h1, {15'h0, hi ? ahi : alo});
   endtask
   task automatic quiet();
      logic seen;
      seen = 1'b0;
      repeat (20) begin step(); if (call === 1'b1) seen = 1'b1; end
      chk("no call", 16'h0, {15'h0, seen});
   endtask
   // reti held over exactly one machine-cycle edge
   task automatic ret();
      reti = 1'b1;
      repeat (2) step();
      reti = 1'b0;
      step();
   endtask
   // ==========
   // scenarios
   task automatic t_vectors();
      for (int i = 0; i < 11; i++) begin
         pc = 16'h1200 + 16'(i);
         raise(i);
         want(i, 1'b0);
         drop(i);
         ret();
         chk("low done", 16'h0, {15'h0, alo});
      end
   endtask
   task automatic t_order();
      gie = 1'b0;
      en[9] = 1'b0;
      raise(9);
      raise(3);
      raise(4);
      quiet();
      chk("pending", 16'h0218, {5'h0, pend});
      gie = 1'b1;
      want(3, 1'b0);
      ret();
      want(4, 1'b0);
      drop(4);
      ret();
      quiet();
      en[9] = 1'b1;
      want(9, 1'b0);
      drop(9);
      ret();
   endtask
   task automatic t_preempt();
      pri[1] = 1'b1;
      raise(4);
      want(4, 1'b0);
      raise(1);
      want(1, 1'b1);
      raise(5);
      quiet();
      ret();
      chk("low kept", 16'h1, {15'h0, alo});
      chk("high done", 16'h0, {15'h0, ahi});
      quiet();
      drop(4);
      ret();
      want(5, 1'b0);
      drop(5);
      ret();
      pri[1] = 1'b0;
   endtask
   task automatic t_block();
      wr = 1'b1;
      raise(5);
      quiet();
      stall = 1'b1;
      wr = 1'b0;
      quiet();
      drop(5);
      repeat (4) step();
      stall = 1'b0;
      quiet();
      reti = 1'b1;
      raise(10);
      quiet();
      reti = 1'b0;
      want(10, 1'b0);
      drop(10);
      ret();
   endtask
   task automatic t_level();
      tt0 = 1'b0;
      tt1 = 1'b0;
      p0_n = 1'b0;
      want(0, 1'b0);
      ret();
      want(0, 1'b0);
      drop(0);
      ret();
      p1_n = 1'b0;
      want(2, 1'b0);
      drop(2);
      ret();
      tt0 = 1'b1;
      tt1 = 1'b1;
   endtask
   task automatic final_report();
      if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge ref_clk_i);
      #1;
      reset_i = 1'b0;
      t_vectors();
      t_order();
      t_preempt();
      t_block();
      t_level();
      final_report();
   end
   initial forever #5 ref_clk_i = ~ref_clk_i;
   initial begin
      #100us;
      error_cnt++;
      final_report();
   end
endmodule
bind tlvi_ctrl tlvi_ctrl_props #(.NSRC(NSRC)) tlvi_ctrl_props_inst (.ref_clk_i, .reset_i,
   .machine_cycle_i, .last_cycle_i, .enable_write_i, .reti_i, .global_int_enable_i,
   .call_req_o, .push_valid_o, .pc_load_o, .pc_vector_o, .flag_clear_o, .active_high_o,
   .active_low_o);
`default_nettype wire

// ### test/tlvi_core_model.sv
// core sequencer and stack model facing the controller
`default_nettype none
module tlvi_core_model (
   input  wire logic        ref_clk_i,
   input  wire logic        reset_i,
   input  wire logic        stall_i,
   input  wire logic        push_valid_i,
   input  wire logic [7:0]  push_byte_i,
   output var  logic        machine_cycle_o,
   output wire logic        last_cycle_o,
   output var  logic [15:0] stack_pc_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========
   // sequencer
   // two-clock machine cycle: short, but keeps sample and poll edges apart
   assign last_cycle_o = !stall_i;
   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         machine_cycle_o <= 1'b0;
         stack_pc_o      <= 16'h0000;
      end else begin
         machine_cycle_o <= !machine_cycle_o;
         if (push_valid_i) stack_pc_o <= {push_byte_i, stack_pc_o[15:8]};
      end
   end
endmodule
`default_nettype wire

// ### test/tlvi_ctrl_props.sv
// assertion checker on the controller top ports
`default_nettype none
module tlvi_ctrl_props #(
   parameter NSRC = 11
) (
   input wire logic            ref_clk_i,
   input wire logic            reset_i,
   input wire logic            machine_cycle_i,
   input wire logic            last_cycle_i,
   input wire logic            enable_write_i,
   input wire logic            reti_i,
   input wire logic            global_int_enable_i,
   input wire logic            call_req_o,
   input wire logic            push_valid_o,
   input wire logic            pc_load_o,
   input wire logic [15:0]     pc_vector_o,
   input wire logic [NSRC-1:0] flag_clear_o,
   input wire logic            active_high_o,
   input wire logic            active_low_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========
   // properties
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   sequence s_push; push_valid_o ##1 push_valid_o; endsequence
   sequence s_load; pc_load_o; endsequence
   property p_seq; call_req_o |=> s_push ##1 s_load; endproperty
   a_seq: assert property (p_seq) else $error("call sequence broken");
   property p_vec; call_req_o && flag_clear_o == 11'h002 |-> ##3 pc_vector_o == 16'h000b;
   endproperty
   a_vec: assert property (p_vec) else $error("timer0 vector");
   property p_gie; call_req_o |-> $past(global_int_enable_i); endproperty
   a_gie: assert property (p_gie) else $error("call while disabled");
   property p_block;
      call_req_o |-> $past(machine_cycle_i && last_cycle_i && !enable_write_i && !reti_i);
   endproperty
   a_block: assert property (p_block) else $error("call while blocked");
   property p_clear; |flag_clear_o |-> call_req_o && (flag_clear_o & 11'h730) == 0;
   endproperty
   a_clear: assert property (p_clear) else $error("bad flag clear");
   property p_reti; reti_i && machine_cycle_i && active_high_o |=> !active_high_o;
   endproperty
   a_reti: assert property (p_reti) else $error("high level kept");
   property p_hold; active_low_o && !(reti_i && machine_cycle_i) |=> active_low_o;
   endproperty
   a_hold: assert property (p_hold) else $error("low level lost");
   property p_defer; call_req_o |-> !$past(active_high_o); endproperty
   a_defer: assert property (p_defer) else $error("high routine entered");
endmodule
`default_nettype wire
